// ### rtl/acr_pkg.sv
/*
 * package for the channel readout port: format codes, timing counts, carrier structs.
 * assumes a 40 MHz system clock; serial clock and frame strobe come from pins.
 */
package acr_pkg;
    localparam int          ACR_NCH          = 8;
    localparam int          ACR_WORD_W       = 24;
    localparam int          ACR_CHANNEL_POWER_KEEP_N_MIN_CYC = 2;
    localparam int          ACR_NDR_SPI      = 130;
    localparam int          ACR_NDR_FS       = 129;
    localparam int          ACR_OSR_HS       = 256;
    localparam int          ACR_OSR_HR       = 512;
    localparam int          ACR_OSR_LS_DIV1  = 2560;
    localparam int          ACR_CNT_W        = 12;
    localparam int          ACR_BIT_W        = 8;
    localparam int          ACR_SLOT_W       = 4;
    localparam logic [2:0]  ACR_FMT_SPI_PACK = 3'h0;
    localparam logic [2:0]  ACR_FMT_SPI_FIX  = 3'h1;
    localparam logic [2:0]  ACR_FMT_SPI_PAR  = 3'h2;
    localparam logic [2:0]  ACR_FMT_FS_PACK  = 3'h3;
    localparam logic [2:0]  ACR_FMT_FS_FIX   = 3'h4;
    localparam logic [2:0]  ACR_FMT_FS_PAR   = 3'h5;
    localparam logic [2:0]  ACR_FMT_MOD      = 3'h6;
    localparam logic [1:0]  ACR_MODE_HS      = 2'h0;
    localparam logic [1:0]  ACR_MODE_HR      = 2'h1;
    localparam logic [1:0]  ACR_MODE_LP      = 2'h2;
    localparam logic [1:0]  ACR_MODE_LS      = 2'h3;

    typedef enum logic [1:0] {
        ACR_ST_IDLE  = 2'h0,
        ACR_ST_READY = 2'h1,
        ACR_ST_SHIFT = 2'h3
    } acr_state_t;

    typedef struct packed {
        logic spi;
        logic tdm;
        logic packed_pos;
        logic modulator;
        logic reserved;
    } acr_fmt_t;

    typedef struct packed {
        logic [ACR_NCH-1:0]               valid;
        logic [ACR_NCH-1:0][ACR_WORD_W-1:0] word;
    } acr_sample_t;
endpackage

// ### rtl/acr_readout_port.sv
/*
 * serial readout port of a multi-channel simultaneous-sampling converter.
 * assumes conversion results arrive as a valid/ready stream on clk_i; serial clock,
 * frame strobe, chain input and power pins are asynchronous and are synchronised here.
 */
// Summary of operation
// RULE1: host holds a channel power pin low at least two clocks to power it down.
// RULE2: all channels down: sleep flag set, outputs driven, serial port and chain ignored.
// RULE3: powered-up channel data valid after 129-130 (spi) or 128-129 (frame) periods.
// RULE4: returning channels realign to the shared sample counter, no sync pulse needed.
// RULE5: format select decodes to protocol, output mode, slot position or modulator.
// RULE6: spi is read-only; sample ready goes low, bits leave msb first on falling edges.
// RULE7: host uses spi only with master clock at or under 27 MHz; the bench runs spi with a 40 MHz clock.
// RULE8: host serial clock no faster than master clock, one clock gap after ready.
// RULE9: ready returns high on first serial falling edge, or pulses high before next result.
// RULE10: new result loads one clock before ready falls, overwriting the shift register; here it loads on the same clock edge that ready falls.
// RULE11: msb valid when ready falls; chain data follow all channel data.
// RULE12: chain input sampled on serial falling edges; lone device ties it low; the bench host drives it high.
// RULE13: frame mode: host runs frame strobe and serial clock continuously.
// RULE14: frame mode serial clock is a power-of-two fraction with enough cycles.
// RULE15: frame strobe period equals the output data period.
// RULE16: frame mode msb presented on frame strobe rise, then shifted on falling edges.
// RULE17: tdm shifts channel 1 first on the first output, then chain data.
// RULE18: parallel mode uses one pin per channel; powered-down channels read zero.
// RULE19: fixed tdm keeps a powered-down channel's slot, filled with zeros.
// RULE20: packed tdm moves higher channels up into vacated slots.
// RULE21: packed tdm admits a newly powered channel only once its data are valid.
// RULE22: format 110 drives serial clock out as modulator clock, outputs carry bit streams.
// RULE23: clocks per sample: 256, 512, 512/256, 2560/512 by mode and ratio select.
// RULE24: parallel outputs drive zero after the 24th serial clock of a sample.
// RULE25: reserved format 111 holds serial outputs low.
`timescale 1ns/10ps
`default_nettype none
module acr_readout_port
    import acr_pkg::*;
#(
    parameter int NCH    = acr_pkg::ACR_NCH,
    parameter int WORD_W = acr_pkg::ACR_WORD_W
) (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // static configuration pins and the asynchronous channel power pins
    input  wire logic [2:0]                   format_i,
    input  wire logic [1:0]                   mode_i,
    input  wire logic                         clock_ratio_sel_i,
    input  wire logic [NCH-1:0]               channel_power_keep_n_i,
    // conversion results and modulator bits from the core
    input  wire acr_pkg::acr_sample_t         sample_i,
    input  wire logic                         sample_valid_i,
    output logic                              sample_ready_o,
    input  wire logic [NCH-1:0]               mod_bits_i,
    // serial pins
    input  wire logic                         sclk_i,
    output logic                              sclk_o,
    output logic                              sclk_oe_o,
    input  wire logic                         frame_strobe_i,
    input  wire logic                         chain_i,
    output logic                              sample_ready_n_o,
    output logic [NCH-1:0]                    dout_o,
    // status
    output logic                              sleep_o,
    output logic [NCH-1:0]                    chan_active_o,
    output logic                              sample_tick_o
);
    localparam int NDR_W = 8;
    // power pins rest high: a low reset value would read as a power-down request after reset
    localparam logic [NCH+2:0] SYNC_IDLE = {3'h0, {NCH{1'b1}}};

    // input synchronisers: two flops per asynchronous pin
    logic [NCH+2:0] sync1_ff;
    logic [NCH+2:0] sync2_ff;
    wire  [NCH+2:0] async_in = {sclk_i, frame_strobe_i, chain_i, channel_power_keep_n_i};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
        end
    end
    wire [NCH-1:0] pwr_s   = sync2_ff[NCH-1:0];
    wire           chain_s = sync2_ff[NCH];
    wire           fs_s    = sync2_ff[NCH+1];
    wire           sclk_s  = sync2_ff[NCH+2];

    logic sclk_d_ff;
    logic fs_d_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_ff <= 1'b0;
            fs_d_ff   <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            fs_d_ff   <= fs_s;
        end
    end
    wire sclk_fall = sclk_d_ff & ~sclk_s;
    wire fs_rise   = fs_s & ~fs_d_ff;

    // format decode
    acr_fmt_t fmt;
    assign fmt.spi        = (format_i <= ACR_FMT_SPI_PAR); // RULE5
    assign fmt.tdm        = (format_i == ACR_FMT_SPI_PACK) || (format_i == ACR_FMT_SPI_FIX) ||
                            (format_i == ACR_FMT_FS_PACK) || (format_i == ACR_FMT_FS_FIX); // RULE5
    assign fmt.packed_pos = (format_i == ACR_FMT_SPI_PACK) || (format_i == ACR_FMT_FS_PACK); // RULE5
    assign fmt.modulator  = (format_i == ACR_FMT_MOD); // RULE5 RULE22
    assign fmt.reserved   = (format_i == 3'h7); // RULE25

    // power-down qualification: a low must stand two clocks before it counts
    logic [NCH-1:0]            pd_ff;
    logic [NCH-1:0]            low1_ff;
    logic [NCH-1:0][NDR_W-1:0] ndr_ff;
    wire  [NDR_W-1:0]          ndr_len = fmt.spi ? NDR_W'(ACR_NDR_SPI) : NDR_W'(ACR_NDR_FS);
    wire                       all_down = &pd_ff;
    logic                      tick;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_pwr
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    low1_ff[g] <= 1'b0;
                    pd_ff[g]   <= 1'b0;
                    // results after power-on stay suppressed for one settle interval
                    ndr_ff[g]  <= NDR_W'(ACR_NDR_SPI);
                end else begin
                    low1_ff[g] <= ~pwr_s[g];
                    if (low1_ff[g] && !pwr_s[g]) begin
                        pd_ff[g] <= 1'b1; // RULE1
                        ndr_ff[g] <= '0;
                    end else if (pwr_s[g] && pd_ff[g]) begin
                        pd_ff[g]  <= 1'b0;
                        ndr_ff[g] <= ndr_len; // RULE3
                    end else if (tick && ndr_ff[g] != '0) begin
                        ndr_ff[g] <= ndr_ff[g] - NDR_W'(1); // RULE3 RULE4
                    end
                end
            end
            assign chan_active_o[g] = ~pd_ff[g] && (ndr_ff[g] == '0); // RULE21
        end
    endgenerate
    assign sleep_o = all_down; // RULE2

    // shared conversion period counter keeps every channel on the same sample grid
    logic [ACR_CNT_W-1:0] per_cnt_ff;
    logic [ACR_CNT_W-1:0] per_len;
    always_comb begin
        case (mode_i)
            ACR_MODE_HS: per_len = ACR_CNT_W'(ACR_OSR_HS); // RULE23
            ACR_MODE_HR: per_len = ACR_CNT_W'(ACR_OSR_HR);
            ACR_MODE_LP: per_len = clock_ratio_sel_i ? ACR_CNT_W'(ACR_OSR_HR) : ACR_CNT_W'(ACR_OSR_HS);
            default:     per_len = clock_ratio_sel_i ? ACR_CNT_W'(ACR_OSR_LS_DIV1) : ACR_CNT_W'(ACR_OSR_HR);
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_cnt_ff <= '0;
        end else if (per_cnt_ff >= per_len - ACR_CNT_W'(1)) begin
            per_cnt_ff <= '0;
        end else begin
            per_cnt_ff <= per_cnt_ff + ACR_CNT_W'(1); // RULE4 RULE23
        end
    end
    assign tick          = (per_cnt_ff == '0);
    assign sample_tick_o = tick;

    // two-entry buffer between core results and the shift register
    acr_sample_t buf_ff [2];
    logic [1:0]  buf_vld_ff;
    logic        wr_ptr_ff;
    logic        rd_ptr_ff;
    wire         buf_full  = &buf_vld_ff;
    wire         buf_pop   = tick && buf_vld_ff[rd_ptr_ff] && !all_down;
    wire         buf_push  = sample_valid_i && !buf_full;
    assign sample_ready_o = !buf_full;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_vld_ff <= '0;
            wr_ptr_ff  <= 1'b0;
            rd_ptr_ff  <= 1'b0;
            buf_ff[0]  <= '0;
            buf_ff[1]  <= '0;
        end else begin
            if (buf_push) begin
                buf_ff[wr_ptr_ff]     <= sample_i;
                buf_vld_ff[wr_ptr_ff] <= 1'b1;
                wr_ptr_ff             <= ~wr_ptr_ff;
            end
            if (buf_pop) begin
                buf_vld_ff[rd_ptr_ff] <= 1'b0;
                rd_ptr_ff             <= ~rd_ptr_ff;
            end
        end
    end
    wire acr_sample_t head = buf_ff[rd_ptr_ff];

    // tdm and parallel images: packed tdm gathers active channels toward slot 0
    logic [NCH*WORD_W-1:0] tdm_img;
    logic [NCH*WORD_W-1:0] par_img;
    logic [ACR_SLOT_W-1:0] n_slot;
    always_comb begin
        int slot;
        tdm_img = '0;
        par_img = '0;
        slot    = 0;
        for (int c = 0; c < NCH; c++) begin
            logic [WORD_W-1:0] w;
            w = (chan_active_o[c] && head.valid[c]) ? head.word[c] : '0; // RULE18 RULE19
            par_img[c*WORD_W +: WORD_W] = w;
            if (fmt.packed_pos) begin
                if (chan_active_o[c]) begin
                    tdm_img[(NCH-1-slot)*WORD_W +: WORD_W] = w; // RULE20 RULE21
                    slot = slot + 1;
                end
            end else begin
                tdm_img[(NCH-1-c)*WORD_W +: WORD_W] = w; // RULE17 RULE19
            end
        end
        n_slot = fmt.packed_pos ? ACR_SLOT_W'(slot) : ACR_SLOT_W'(NCH);
    end

    // output shift engine
    acr_state_t                state_ff;
    logic [NCH*WORD_W-1:0]     tdm_sr_ff;
    logic [NCH-1:0][WORD_W-1:0] par_sr_ff;
    logic [ACR_BIT_W-1:0]      par_bits_ff;
    logic                      rdy_n_ff;
    logic                      pulse_ff;
    logic [ACR_SLOT_W-1:0]     slots_ff;
    // chain bits enter just below the last occupied slot, so a packed frame ends early
    wire  [NCH*WORD_W-1:0]     chain_at   = (NCH*WORD_W)'(1) << ((NCH - int'(slots_ff)) * WORD_W); // RULE20
    wire  [NCH*WORD_W-1:0]     tdm_shift  = {tdm_sr_ff[NCH*WORD_W-2:0], 1'b0} | (chain_s ? chain_at : '0);
    wire                       port_on    = !all_down && !fmt.modulator && !fmt.reserved; // RULE2 RULE25
    wire                       load_spi   = fmt.spi && buf_pop; // RULE10
    wire                       load_fs    = !fmt.spi && fs_rise; // RULE16
    wire                       do_load    = port_on && (load_spi || (load_fs && buf_vld_ff[rd_ptr_ff]));
    wire                       do_shift   = port_on && sclk_fall && (state_ff == ACR_ST_SHIFT ||
                                            state_ff == ACR_ST_READY); // RULE6 RULE12
    wire                       pre_pulse  = fmt.spi && !rdy_n_ff && (per_cnt_ff == per_len - ACR_CNT_W'(1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= ACR_ST_IDLE;
            tdm_sr_ff   <= '0;
            par_sr_ff   <= '0;
            par_bits_ff <= '0;
            rdy_n_ff    <= 1'b1;
            pulse_ff    <= 1'b0;
            slots_ff    <= '0;
        end else begin
            pulse_ff <= pre_pulse;
            if (!port_on) begin
                state_ff  <= ACR_ST_IDLE;
                rdy_n_ff  <= 1'b1;
                tdm_sr_ff <= '0;
                par_sr_ff <= '0;
            end else if (do_load) begin
                tdm_sr_ff   <= tdm_img; // RULE10 RULE11 RULE16
                par_sr_ff   <= par_img;
                slots_ff    <= n_slot; // RULE21
                par_bits_ff <= '0;
                rdy_n_ff    <= !fmt.spi; // RULE6
                state_ff    <= ACR_ST_READY;
            end else if (pre_pulse) begin
                rdy_n_ff <= 1'b1; // RULE9
            end else if (pulse_ff && state_ff == ACR_ST_READY) begin
                rdy_n_ff <= !fmt.spi;
            end else if (do_shift) begin
                rdy_n_ff  <= 1'b1; // RULE9
                state_ff  <= ACR_ST_SHIFT;
                tdm_sr_ff <= tdm_shift; // RULE11 RULE12 RULE17
                for (int c = 0; c < NCH; c++) begin
                    par_sr_ff[c] <= {par_sr_ff[c][WORD_W-2:0], (c == 0) ? chain_s : 1'b0}; // RULE24
                end
                if (par_bits_ff != ACR_BIT_W'(WORD_W)) begin
                    par_bits_ff <= par_bits_ff + ACR_BIT_W'(1);
                end
            end
        end
    end

    // modulator clock: divided master clock by mode
    logic [5:0] mdiv_ff;
    logic       mclk_ff;
    wire  [5:0] mhalf = (mode_i == ACR_MODE_LS) ? (clock_ratio_sel_i ? 6'h14 : 6'h04) :
                        (mode_i == ACR_MODE_LP && clock_ratio_sel_i) ? 6'h04 : 6'h02;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdiv_ff <= '0;
            mclk_ff <= 1'b0;
        end else if (mdiv_ff >= mhalf - 6'h01) begin
            mdiv_ff <= '0;
            mclk_ff <= ~mclk_ff; // RULE22
        end else begin
            mdiv_ff <= mdiv_ff + 6'h01;
        end
    end

    // pin drive
    wire tdm_mode = fmt.tdm;
    generate
        for (g = 0; g < NCH; g++) begin : g_dout
            wire par_bit  = (par_bits_ff < ACR_BIT_W'(WORD_W)) ? par_sr_ff[g][WORD_W-1] : 1'b0; // RULE24
            wire tdm_bit  = (g == 0) ? tdm_sr_ff[NCH*WORD_W-1] : 1'b0; // RULE17
            assign dout_o[g] = fmt.reserved ? 1'b0 :                      // RULE25
                               fmt.modulator ? (mod_bits_i[g] & ~pd_ff[g]) : // RULE22
                               !port_on ? 1'b0 :
                               tdm_mode ? tdm_bit : (par_bit & chan_active_o[g]); // RULE18
        end
    endgenerate
    assign sample_ready_n_o = !fmt.spi ? 1'b1 : rdy_n_ff; // RULE2 RULE6
    assign sclk_o           = fmt.modulator ? mclk_ff : 1'b0;
    assign sclk_oe_o        = fmt.modulator; // RULE22
endmodule
`default_nettype wire

// ### test/acr_host_model.sv
/* host model: reads the serial port, or runs frames in frame mode.
   assumes a 40 MHz clock and the high-speed sample period in frame mode. */
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
    // clock and mode
    input  wire logic        clk_i,
    input  wire logic        frame_mode_i,
    // device pins
    input  wire logic        ready_n_i,
    input  wire logic [7:0]  dout_i,
    output logic             sclk_o,
    output logic             frame_strobe_o,
    output logic             chain_o,
    // one captured dout vector per bit
    output logic [27:0][7:0] cap_o,
    output logic             done_o
);
    initial begin
        sclk_o = 1'b0;
        frame_strobe_o = 1'b0;
        chain_o = 1'b1;
        cap_o = '0;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (frame_mode_i) begin
                // sclk never stops inside frame mode, 256 clocks per frame
                for (int i = 0; i < 32; i++) begin
                    sclk_o <= 1'b1;
                    frame_strobe_o <= (i < 16);
                    done_o <= (i >= 28);
                    repeat (4) @(posedge clk_i);
                    if (i < 28) cap_o[i] <= dout_i;
                    sclk_o <= 1'b0;
                    repeat ((i == 31) ? 3 : 4) @(posedge clk_i);
                end
            end else if (!ready_n_i) begin
                done_o <= 1'b0;
                // 28 bits at clk/8 end well before the next load
                for (int i = 0; i < 28; i++) begin
                    @(posedge clk_i);
                    sclk_o <= 1'b1;
                    repeat (3) @(posedge clk_i);
                    cap_o[i] <= dout_i;
                    sclk_o <= 1'b0;
                    repeat (4) @(posedge clk_i);
                end
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/acr_readout_port_asserts.sv
/* checker for the readout port pins, bound to the top module.
   assumes one clock domain and a static format select. */
`timescale 1ns/10ps
`default_nettype none
module acr_readout_port_asserts
    import acr_pkg::*;
#(parameter int NCH = 8) (
    // clock, reset, configuration
    input wire logic           clk_i,
    input wire logic           rst_n_i,
    input wire logic [2:0]     format_i,
    input wire logic [1:0]     mode_i,
    input wire logic           clock_ratio_sel_i,
    input wire logic [NCH-1:0] channel_power_keep_n_i,
    // pins and status
    input wire logic           sclk_i,
    input wire logic           sclk_oe_o,
    input wire logic           sample_ready_n_o,
    input wire logic [NCH-1:0] dout_o,
    input wire logic           sleep_o,
    input wire logic [NCH-1:0] chan_active_o,
    input wire logic           sample_tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [11:0] gap_ff;
    logic        ok_ff;
    wire logic [11:0] exp_gap = (mode_i == ACR_MODE_HS) ? 12'hff : (mode_i == ACR_MODE_HR) ? 12'h1ff :
        (mode_i == ACR_MODE_LP) ? (clock_ratio_sel_i ? 12'h1ff : 12'hff) : (clock_ratio_sel_i ? 12'h9ff : 12'h1ff);
    // a mode change voids the interval in flight
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_ff <= 12'h0;
            ok_ff  <= 1'b0;
        end else begin
            gap_ff <= sample_tick_o ? 12'h0 : gap_ff + 12'h1;
            ok_ff  <= (sample_tick_o | ok_ff) & $stable(mode_i) & $stable(clock_ratio_sel_i);
        end
    end
    tick_gap_a: assert property (sample_tick_o && ok_ff |-> gap_ff == exp_gap)
        else $error("sample period length wrong");
    ready_release_a: assert property (!sample_ready_n_o && $fell(sclk_i) |-> ##[1:6] sample_ready_n_o)
        else $error("ready not released after serial clock fall");
    ready_spi_a: assert property ($fell(sample_ready_n_o) |-> format_i < 3'h3 || $past(format_i) < 3'h3)
        else $error("ready fell outside spi formats");
    mod_oe_off_a: assert property (sclk_oe_o |-> format_i == ACR_FMT_MOD || $past(format_i) == ACR_FMT_MOD)
        else $error("serial clock driven outside modulator format");
    mod_oe_on_a: assert property (format_i == ACR_FMT_MOD && $past(format_i, 2) == ACR_FMT_MOD |-> sclk_oe_o)
        else $error("modulator clock not driven");
    reserved_low_a: assert property ((format_i == 3'h7) [*4] |-> dout_o == '0)
        else $error("outputs not low in reserved format");
    sleep_quiet_a: assert property (sleep_o && $past(sleep_o, 2) && format_i != ACR_FMT_MOD |->
        dout_o == '0 && !$fell(sample_ready_n_o)) else $error("port active while asleep");
    sleep_entry_a: assert property ((channel_power_keep_n_i == '0) [*5] |-> sleep_o)
        else $error("no sleep with all channels down");
    par_zero_a: assert property ((format_i == ACR_FMT_SPI_PAR || format_i == ACR_FMT_FS_PAR) &&
        $stable(format_i) |-> (dout_o & ~chan_active_o) == '0) else $error("inactive channel pin not zero");
    spi_read_c: cover property ($fell(sample_ready_n_o));
    sleep_c: cover property ($rose(sleep_o));
    mod_c: cover property ($rose(sclk_oe_o));
endmodule
bind acr_readout_port acr_readout_port_asserts #(.NCH(NCH)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .format_i(format_i), .mode_i(mode_i), .clock_ratio_sel_i(clock_ratio_sel_i),
    .channel_power_keep_n_i(channel_power_keep_n_i), .sclk_i(sclk_i), .sclk_oe_o(sclk_oe_o),
    .sample_ready_n_o(sample_ready_n_o), .dout_o(dout_o), .sleep_o(sleep_o),
    .chan_active_o(chan_active_o), .sample_tick_o(sample_tick_o));
`default_nettype wire

// ### test/acr_readout_port_test.sv
/* self-checking bench for the readout port with a host model.
   assumes the default eight channels of 24 bits. */
`timescale 1ns/10ps
`default_nettype none
module acr_readout_port_test;
    import acr_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ratio = 1'b1, valid = 1'b0, fmode = 1'b0;
    logic [2:0] format_i = ACR_FMT_SPI_PACK;
    logic [1:0] mode_i = ACR_MODE_HS;
    logic [7:0] keep_n = 8'hff, mod_bits = 8'h0;
    acr_sample_t smp = '0;
    logic h_sclk, m_clk, sclk_oe, fstb, chain, rdy_n, sleep, tick, s_rdy, hdone;
    logic [7:0] dout, act;
    logic [27:0][7:0] cap;
    logic [31:0] seed = 32'h42261006;
    logic [2:0] fmts [7] = '{3'h0, 3'h2, 3'h1, 3'h0, 3'h2, 3'h0, 3'h1};
    logic [7:0] masks [7] = '{8'hff, 8'hff, 8'hfa, 8'hfa, 8'hfa, 8'h08, 8'h08};
    int n_mismatch = 0, cmp_count = 0, cyc = 0, k;
    // the modulator clock owns the pin whenever its enable is high
    wire logic sclk_w = sclk_oe ? m_clk : h_sclk;
    acr_readout_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .format_i(format_i), .mode_i(mode_i),
        .clock_ratio_sel_i(ratio), .channel_power_keep_n_i(keep_n), .sample_i(smp), .sample_valid_i(valid),
        .sample_ready_o(s_rdy), .mod_bits_i(mod_bits), .sclk_i(sclk_w), .sclk_o(m_clk), .sclk_oe_o(sclk_oe),
        .frame_strobe_i(fstb), .chain_i(chain), .sample_ready_n_o(rdy_n), .dout_o(dout), .sleep_o(sleep),
        .chan_active_o(act), .sample_tick_o(tick));
    acr_host_model host (.clk_i(clk_i), .frame_mode_i(fmode), .ready_n_i(rdy_n), .dout_i(dout),
        .sclk_o(h_sclk), .frame_strobe_o(fstb), .chain_o(chain), .cap_o(cap), .done_o(hdone));
    always #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // first 28 bits on pin 0; chain ones follow the channel slots
    function automatic logic [27:0] exp_tdm(input logic pk, input logic [7:0] on);
        logic [27:0] r;
        int n;
        r = '1;
        n = 27;
        for (int c = 0; c < 8; c++)
            if (on[c] || !pk)
                for (int b = 23; b >= 0; b--) begin
                    if (n >= 0) r[n] = on[c] & smp.word[c][b];
                    n--;
                end
        return r;
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_i iff tick === 1'b1);
    endtask
    task automatic setup(input logic [2:0] f, input logic [7:0] m);
        @(posedge clk_i);
        format_i <= f;
        keep_n <= m;
        for (int c = 0; c < 8; c++) begin
            seed = xs(seed);
            smp.word[c] <= seed[23:0];
        end
        smp.valid <= 8'hff;
    endtask
    task automatic read_chk(input logic [2:0] f, input logic [7:0] on);
        logic [27:0] e, g;
        @(negedge clk_i iff hdone === 1'b0);
        @(negedge clk_i iff hdone === 1'b1);
        for (int p = 0; p < 8; p++) begin
            for (int i = 0; i < 28; i++) begin
                g[27-i] = cap[i][p];
                e[27-i] = (i < 24) ? on[p] & smp.word[p][23-i] : 1'b0;
            end
            if (f == ACR_FMT_SPI_PAR || f == ACR_FMT_FS_PAR)
                chk("parallel pin", {4'h0, e}, {4'h0, g});
            else if (p == 0)
                chk("tdm stream", {4'h0, exp_tdm(f == ACR_FMT_SPI_PACK || f == ACR_FMT_FS_PACK, on)},
                    {4'h0, g});
        end
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        setup(ACR_FMT_SPI_PACK, 8'hff);
        valid <= 1'b1;
        k = 0;
        repeat (6) begin
            @(negedge clk_i);
            k += s_rdy;
        end
        chk("buffer depth", 32'h2, k);
        k = 0;
        while (act !== 8'hff) begin
            ticks(1);
            k++;
        end
        chk("settle ticks", 32'h1, {31'h0, k >= ACR_NDR_FS - 1 && k <= ACR_NDR_SPI + 1});
        for (int t = 0; t < 7; t++) begin
            setup(fmts[t], masks[t]);
            ticks(4);
            read_chk(fmts[t], masks[t]);
        end
        setup(ACR_FMT_SPI_PACK, 8'h09);
        ticks(4);
        read_chk(ACR_FMT_SPI_PACK, 8'h08);
        chk("new channel active", 32'h0, {31'h0, act[0]});
        for (int t = 3; t < 6; t++) begin
            setup(t[2:0], 8'h08);
            fmode <= 1'b1;
            ticks(3);
            chk("ready in frame mode", 32'h1, {31'h0, rdy_n});
            read_chk(t[2:0], 8'h08);
        end
        setup(ACR_FMT_MOD, 8'h08);
        fmode <= 1'b0;
        mod_bits <= seed[7:0];
        repeat (8) @(negedge clk_i);
        chk("modulator bit", {31'h0, mod_bits[3]}, {31'h0, dout[3]});
        chk("modulator clock enable", 32'h1, {31'h0, sclk_oe});
        setup(3'h7, 8'h08);
        repeat (8) @(negedge clk_i);
        chk("reserved outputs", 32'h0, {24'h0, dout});
        setup(ACR_FMT_SPI_FIX, 8'h08);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_i);
            mode_i <= m[2:1];
            ratio <= m[0];
            ticks(3);
        end
        k = cyc;
        ticks(1);
        chk("sample period", ACR_OSR_LS_DIV1, cyc - k);
        setup(ACR_FMT_SPI_FIX, 8'h00);
        repeat (20) @(negedge clk_i);
        chk("sleep flag", 32'h1, {31'h0, sleep});
        test_done;
    end
endmodule
`default_nettype wire
